// ==== exec_cfg.svh ====
// constants of the instruction execution unit: bus offsets, field positions,
// widths, reset values and cycle counts; definitions only
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// ------------------------------------------------------------------
// sizes
// ------------------------------------------------------------------
`define DATA_W      8
`define MEM_AW      5
`define MEM_DEPTH   32
`define PC_W        12
`define STK_AW      3
`define STK_DEPTH   8
`define ADR_W       8
`define CNT_W       16

// ------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ------------------------------------------------------------------
`define REG_CMD     8'h00
`define REG_ACC     8'h04
`define REG_FLAGS   8'h08
`define REG_PC      8'h0C
`define REG_STACK   8'h10
`define REG_CTRL    8'h14
`define REG_STAT    8'h18
`define REG_COUNT   8'h1C
`define MEM_SEL_BIT 7

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CMD_OP_LSB    0
`define CMD_ADR_LSB   8
`define CMD_IMM_LSB   16
`define STAT_BUSY     0
`define STAT_SKIP     1
`define STAT_CYC_LSB  2
`define STAT_ERR      4
`define STAT_SP_LSB   8
`define CTRL_GIE      0

// ------------------------------------------------------------------
// reset values and cycle counts
// ------------------------------------------------------------------
`define ACC_RESET   8'h00
`define PC_RESET    12'h000
`define CYC_ONE     2'h1
`define CYC_TWO     2'h2

`endif

// ==== exec_pkg.sv ====
// types shared by the execution unit and its arithmetic/logic stage
// assumes exec_cfg.svh is on the include path
`include "exec_cfg.svh"

package exec_pkg;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NO_OPERATION                        = 5'h00,
        OP_MOVE_MEM_TO_ACC                     = 5'h01,
        OP_MOVE_IMM_TO_ACC                     = 5'h02,
        OP_MOVE_ACC_TO_MEM                     = 5'h03,
        OP_OR_MEM_TO_ACC                       = 5'h04,
        OP_OR_IMM_TO_ACC                       = 5'h05,
        OP_OR_TO_MEMORY                        = 5'h06,
        OP_SUBROUTINE_RETURN                   = 5'h07,
        OP_RETURN_WITH_VALUE                   = 5'h08,
        OP_INTERRUPT_RETURN                    = 5'h09,
        OP_ROTATE_LEFT_IN_PLACE                = 5'h0A,
        OP_ROTATE_LEFT_TO_ACCUMULATOR          = 5'h0B,
        OP_ROTATE_LEFT_THROUGH_CARRY           = 5'h0C,
        OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR    = 5'h0D,
        OP_ROTATE_RIGHT_IN_PLACE               = 5'h0E,
        OP_ROTATE_RIGHT_TO_ACCUMULATOR         = 5'h0F,
        OP_ROTATE_RIGHT_THROUGH_CARRY          = 5'h10,
        OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR   = 5'h11,
        OP_SUBTRACT_BORROW_TO_ACCUMULATOR      = 5'h12,
        OP_SUBTRACT_BORROW_TO_MEMORY           = 5'h13,
        OP_DECREMENT_SKIP_IF_ZERO              = 5'h14,
        OP_DECREMENT_TO_ACCUMULATOR_SKIP_IF_ZERO = 5'h15
    } op_t;

    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } flags_t;

    typedef struct packed {
        logic [`DATA_W-1:0] result;
        logic               wr_acc;
        logic               wr_mem;
        logic               skip;
        logic               is_return;
        logic               set_gie;
        logic               illegal;
        flags_t             flags;
    } alu_out_t;

    // gray along idle -> exec -> dummy; bit 0 doubles as busy
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_DUMMY = 2'b11
    } exec_state_t;

endpackage

// ==== exec_alu.sv ====
// combinational result and flag stage of the execution unit
// assumes operands are stable for the whole execute cycle
`timescale 1ns/1ps
`include "exec_cfg.svh"

module exec_alu
    import exec_pkg::*;
(
    input  wire op_t                op_i,
    input  wire logic [`DATA_W-1:0] acc_i,
    input  wire logic [`DATA_W-1:0] mem_i,
    input  wire logic [`DATA_W-1:0] imm_i,
    input  wire flags_t             flags_i,
    output alu_out_t                out_o
);

    logic [`DATA_W:0]   sum;
    logic [4:0]         low;
    logic [`DATA_W-1:0] dec;
    logic               cin;
    logic               zupd;

    always_comb
    begin
        cin  = flags_i.carry_flag;
        // subtraction as acc + ~m + carry, carry meaning "no borrow"
        sum  = {1'b0, acc_i} + {1'b0, ~mem_i} + {8'h00, cin};
        low  = {1'b0, acc_i[3:0]} + {1'b0, ~mem_i[3:0]} + {4'h0, cin};
        dec  = mem_i - 8'h01;
        zupd = 1'b0;
        out_o = '0;
        out_o.flags = flags_i;
        unique case (op_i)
            OP_NO_OPERATION: ;
            OP_MOVE_MEM_TO_ACC:
            begin
                out_o.result = mem_i;
                out_o.wr_acc = 1'b1;
            end
            OP_MOVE_IMM_TO_ACC:
            begin
                out_o.result = imm_i;
                out_o.wr_acc = 1'b1;
            end
            OP_MOVE_ACC_TO_MEM:
            begin
                out_o.result = acc_i;
                out_o.wr_mem = 1'b1;
            end
            OP_OR_MEM_TO_ACC, OP_OR_IMM_TO_ACC:
            begin
                out_o.result = acc_i | ((op_i == OP_OR_IMM_TO_ACC) ? imm_i : mem_i);
                out_o.wr_acc = 1'b1;
                zupd = 1'b1;
            end
            OP_OR_TO_MEMORY:
            begin
                out_o.result = acc_i | mem_i;
                out_o.wr_mem = 1'b1;
                zupd = 1'b1;
            end
            OP_SUBROUTINE_RETURN: out_o.is_return = 1'b1;
            OP_RETURN_WITH_VALUE:
            begin
                out_o.is_return = 1'b1;
                out_o.result = imm_i;
                out_o.wr_acc = 1'b1;
            end
            OP_INTERRUPT_RETURN:
            begin
                out_o.is_return = 1'b1;
                out_o.set_gie = 1'b1;
            end
            OP_ROTATE_LEFT_IN_PLACE, OP_ROTATE_LEFT_TO_ACCUMULATOR:
            begin
                out_o.result = {mem_i[6:0], mem_i[7]};
                out_o.wr_mem = (op_i == OP_ROTATE_LEFT_IN_PLACE);
                out_o.wr_acc = !out_o.wr_mem;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR:
            begin
                out_o.result = {mem_i[6:0], cin};
                out_o.flags.carry_flag = mem_i[7];
                out_o.wr_mem = (op_i == OP_ROTATE_LEFT_THROUGH_CARRY);
                out_o.wr_acc = !out_o.wr_mem;
            end
            OP_ROTATE_RIGHT_IN_PLACE, OP_ROTATE_RIGHT_TO_ACCUMULATOR:
            begin
                out_o.result = {mem_i[0], mem_i[7:1]};
                out_o.wr_mem = (op_i == OP_ROTATE_RIGHT_IN_PLACE);
                out_o.wr_acc = !out_o.wr_mem;
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR:
            begin
                out_o.result = {cin, mem_i[7:1]};
                out_o.flags.carry_flag = mem_i[0];
                out_o.wr_mem = (op_i == OP_ROTATE_RIGHT_THROUGH_CARRY);
                out_o.wr_acc = !out_o.wr_mem;
            end
            OP_SUBTRACT_BORROW_TO_ACCUMULATOR, OP_SUBTRACT_BORROW_TO_MEMORY:
            begin
                out_o.result = sum[7:0];
                out_o.flags.carry_flag = sum[8];
                out_o.flags.aux_carry_flag = low[4];
                out_o.flags.overflow_flag = (acc_i[7] == ~mem_i[7]) && (sum[7] != acc_i[7]);
                out_o.wr_mem = (op_i == OP_SUBTRACT_BORROW_TO_MEMORY);
                out_o.wr_acc = !out_o.wr_mem;
                zupd = 1'b1;
            end
            OP_DECREMENT_SKIP_IF_ZERO, OP_DECREMENT_TO_ACCUMULATOR_SKIP_IF_ZERO:
            begin
                out_o.result = dec;
                out_o.skip = (dec == 8'h00);
                out_o.wr_mem = (op_i == OP_DECREMENT_SKIP_IF_ZERO);
                out_o.wr_acc = !out_o.wr_mem;
            end
            default: out_o.illegal = 1'b1;
        endcase
        if (zupd)
        begin
            out_o.flags.zero_flag = (out_o.result == 8'h00);
        end
    end

endmodule // exec_alu

// ==== mcu_exec_unit.sv ====
// instruction execution unit: accumulator, flags, data memory, return stack
// and program counter, commanded and inspected over a classic Wishbone slave
// assumes a single 25 MHz clock and a synchronous active-high reset
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module mcu_exec_unit
    import exec_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [`ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   busy_o,
    output logic                   global_interrupt_enable_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        exec_state_t                            st;
        op_t                                    op;
        logic [`MEM_AW-1:0]                     addr;
        logic [`DATA_W-1:0]                     imm;
        logic [`DATA_W-1:0]                     accumulator;
        flags_t                                 flags;
        logic                                   global_interrupt_enable;
        logic [`PC_W-1:0]                       pc;
        logic [`STK_DEPTH-1:0][`PC_W-1:0]       stack;
        logic [`STK_AW-1:0]                     sp;
        logic [`MEM_DEPTH-1:0][`DATA_W-1:0]     mem;
        logic                                   skip;
        logic [1:0]                             last_cycles;
        logic                                   cmd_error;
        logic [`CNT_W-1:0]                      count;
        logic                                   ack;
        logic [31:0]                            rdata;
    } state_t;

    state_t             q;
    state_t             d;
    alu_out_t           alu;
    logic               req;
    logic               wr;
    logic [31:0]        wmask;
    logic [`PC_W-1:0]   top;
    logic               mem_hit;
    logic [`MEM_AW-1:0] mem_idx;
    logic               lane_byte;
    logic               lane_cmd;
    logic               lane_push;

    // ------------------------------------------------------------------
    // result stage
    // ------------------------------------------------------------------
    exec_alu u_alu (
        .op_i    (q.op),
        .acc_i   (q.accumulator),
        .mem_i   (q.mem[q.addr]),
        .imm_i   (q.imm),
        .flags_i (q.flags),
        .out_o   (alu)
    );

    // byte lanes as a bit mask, so partial writes keep unselected bytes
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // data memory fills the upper half of the map, one byte per aligned word
    assign mem_hit   = wb_adr_i[`MEM_SEL_BIT];
    assign mem_idx   = wb_adr_i[`MEM_AW+1:2];
    // a register other than the PC is only touched when every lane it needs is enabled,
    // so a narrow write never leaves a half-built command or stack entry behind
    assign lane_byte = wb_sel_i[0];
    assign lane_cmd  = (wb_sel_i[2:0] == 3'h7);
    assign lane_push = (wb_sel_i[1:0] == 2'h3);

    assign req = wb_cyc_i && wb_stb_i && !q.ack;
    // software may not disturb state while an instruction is in flight
    assign wr  = req && wb_we_i && (q.st == ST_IDLE);
    assign top = q.stack[`STK_AW'(q.sp - 1'b1)];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.ack = 1'b0;

        // ---- bus reads: answered one cycle after the request ----
        if (req)
        begin
            d.ack = 1'b1;
            d.rdata = 32'h0000_0000;
            if (mem_hit)
            begin
                d.rdata[7:0] = q.mem[mem_idx];
            end
            else
            begin
                unique case (wb_adr_i)
                    `REG_CMD:
                    begin
                        d.rdata[`CMD_OP_LSB +: 5] = q.op;
                        d.rdata[`CMD_ADR_LSB +: `MEM_AW] = q.addr;
                        d.rdata[`CMD_IMM_LSB +: 8] = q.imm;
                    end
                    `REG_ACC:
                    begin
                        d.rdata[7:0] = q.accumulator;
                    end
                    `REG_FLAGS:
                    begin
                        d.rdata[5:0] = q.flags;
                    end
                    `REG_PC:
                    begin
                        d.rdata[`PC_W-1:0] = q.pc;
                    end
                    `REG_STACK:
                    begin
                        // reading the top entry does not pop it
                        d.rdata[`PC_W-1:0] = top;
                    end
                    `REG_CTRL:
                    begin
                        d.rdata[`CTRL_GIE] = q.global_interrupt_enable;
                    end
                    `REG_STAT:
                    begin
                        d.rdata[`STAT_BUSY] = q.st[0];
                        d.rdata[`STAT_SKIP] = q.skip;
                        d.rdata[`STAT_CYC_LSB +: 2] = q.last_cycles;
                        d.rdata[`STAT_ERR] = q.cmd_error;
                        d.rdata[`STAT_SP_LSB +: `STK_AW] = q.sp;
                    end
                    `REG_COUNT:
                    begin
                        d.rdata[`CNT_W-1:0] = q.count;
                    end
                    default:
                    begin
                        // unmapped words read as zero
                        d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // ---- bus writes: take effect at the edge that raises ack ----
        if (wr)
        begin
            if (mem_hit)
            begin
                if (lane_byte)
                begin
                    d.mem[mem_idx] = wb_dat_i[7:0];
                end
            end
            else
            begin
                unique case (wb_adr_i)
                    `REG_CMD:
                    begin
                        // a command needs all three low lanes to be meaningful
                        if (lane_cmd)
                        begin
                            d.op   = op_t'(wb_dat_i[`CMD_OP_LSB +: 5]);
                            d.addr = wb_dat_i[`CMD_ADR_LSB +: `MEM_AW];
                            d.imm  = wb_dat_i[`CMD_IMM_LSB +: 8];
                            d.st   = ST_EXEC;
                        end
                    end
                    `REG_ACC:
                    begin
                        if (lane_byte)
                        begin
                            d.accumulator = wb_dat_i[7:0];
                        end
                    end
                    `REG_FLAGS:
                    begin
                        if (lane_byte)
                        begin
                            d.flags = wb_dat_i[5:0];
                        end
                    end
                    `REG_PC:
                    begin
                        d.pc = (q.pc & ~wmask[`PC_W-1:0]) | (wb_dat_i[`PC_W-1:0]
                               & wmask[`PC_W-1:0]);
                    end
                    `REG_STACK:
                    begin
                        // push; the ninth push overwrites the oldest entry
                        if (lane_push)
                        begin
                            d.stack[q.sp] = wb_dat_i[`PC_W-1:0];
                            d.sp = `STK_AW'(q.sp + 1'b1);
                        end
                    end
                    `REG_CTRL:
                    begin
                        if (lane_byte)
                        begin
                            d.global_interrupt_enable = wb_dat_i[`CTRL_GIE];
                        end
                    end
                    `REG_STAT:
                    begin
                        // write one clears the error flag
                        if (lane_byte && wb_dat_i[`STAT_ERR])
                        begin
                            d.cmd_error = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // ---- execution ----
        unique case (q.st)
            ST_IDLE:
            begin
                // nothing executes until software writes a command
            end
            ST_EXEC:
            begin
                d.pc = `PC_W'(q.pc + 1'b1);
                d.count = `CNT_W'(q.count + 1'b1);
                if (alu.wr_acc)
                begin
                    d.accumulator = alu.result;
                end
                if (alu.wr_mem)
                begin
                    d.mem[q.addr] = alu.result;
                end
                d.flags = alu.flags;
                if (alu.set_gie)
                begin
                    d.global_interrupt_enable = 1'b1;
                end
                // the error flag is only set while idle writes are blocked, so no race
                if (alu.illegal)
                begin
                    d.cmd_error = 1'b1;
                end
                if (alu.is_return)
                begin
                    d.pc = top;
                    d.sp = `STK_AW'(q.sp - 1'b1);
                end
                d.skip = alu.skip;
                // two cycles on return or skip
                if (alu.is_return || alu.skip)
                begin
                    d.st = ST_DUMMY;
                    d.last_cycles = `CYC_TWO;
                end
                else
                begin
                    d.st = ST_IDLE;
                    d.last_cycles = `CYC_ONE;
                end
            end
            ST_DUMMY:
            begin
                if (q.skip)
                begin
                    d.pc = `PC_W'(q.pc + 1'b1);
                end
                d.st = ST_IDLE;
            end
            default:
            begin
                // the unused state code falls back to idle instead of hanging with bus writes blocked
                d.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.accumulator <= `ACC_RESET;
            q.pc <= `PC_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdata;
    // state bit 0 is high in both busy states
    assign busy_o = q.st[0];
    assign global_interrupt_enable_o = q.global_interrupt_enable;

endmodule // mcu_exec_unit

// ==== exec_props.sv ====
// timing checks on the execution unit's busy and global interrupt enable outputs
// assumes a bind onto mcu_exec_unit
`timescale 1ns/1ps
module exec_props
    import exec_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        busy_o,
    input wire logic        global_interrupt_enable_o
);
    logic       wr;
    logic       tk;
    logic [4:0] op;
    logic       gie_wr;
    logic       ri;
    // writes during busy are dropped, so they start nothing
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & !busy_o;
    assign tk = wr && wb_adr_i == 8'h00 && wb_sel_i[2:0] == 3'h7;
    assign op = wb_dat_i[4:0];
    assign gie_wr = wr && wb_adr_i == 8'h14 && wb_sel_i[0];
    assign ri = tk && op == 5'h09;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_nop; tk && op == 5'h00 |=> busy_o ##1 !busy_o; endproperty
    a_nop: assert property (p_nop) else $error("nop length wrong");
    property p_one; tk && op inside {[1:6], [10:19]} |=> busy_o ##1 !busy_o; endproperty
    a_one: assert property (p_one) else $error("single cycle op length wrong");
    property p_ret; tk && op == 5'h07 |=> busy_o [*2] ##1 !busy_o; endproperty
    a_ret: assert property (p_ret) else $error("return length wrong");
    property p_rv; tk && op == 5'h08 |=> busy_o [*2] ##1 !busy_o; endproperty
    a_rv: assert property (p_rv) else $error("value return length wrong");
    property p_ri; tk && op == 5'h09 |=> busy_o ##1 busy_o && global_interrupt_enable_o
        ##1 !busy_o; endproperty
    a_ri: assert property (p_ri) else $error("interrupt return wrong");
    property p_dz; tk && op inside {20, 21} |=> busy_o ##2 !busy_o; endproperty
    a_dz: assert property (p_dz) else $error("decrement skip length wrong");
    property p_gf; $fell(global_interrupt_enable_o) |-> $past(gie_wr)
        || $past(rst_i); endproperty
    a_gf: assert property (p_gf) else $error("enable dropped by an op");
    property p_gr; $rose(global_interrupt_enable_o) |-> $past(gie_wr)
        || $past(ri, 2); endproperty
    a_gr: assert property (p_gr) else $error("enable raised without cause");
endmodule // exec_props

// ==== testbench.sv ====
// self-checking bench: drives the unit over its bus, reads results back
// assumes package, design and exec_props are compiled first
`timescale 1ns/1ps
module testbench;
    logic        clk_i, rst_i, cyc, we, ack, busy, gie;
    logic [7:0]  adr;
    logic [31:0] dat, rd, q;
    int          failures, checks_done;
    mcu_exec_unit u_mcu_exec_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rd), .wb_ack_o(ack), .busy_o(busy), .global_interrupt_enable_o(gie));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        checks_done++;
        if (q !== e)
        begin
            failures++;
            $display("Error %0t: at %h read %h not %h", $time, a, q, e);
        end
    endtask
    task automatic chk_pin(input logic v, input logic e);
        checks_done++;
        if (v !== e)
        begin
            failures++;
            $display("Error %0t: pin %b not %b", $time, v, e);
        end
    endtask
    task automatic ex(input logic [4:0] o, input logic [4:0] m, input logic [7:0] i);
        bus(1'b1, 8'h00, {8'h00, i, 3'h0, m, 3'h0, o});
        for (int n = 0; n < 4 && busy !== 1'b0; n++) @(posedge clk_i);
        chk_pin(busy, 1'b0);
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] m, input logic [5:0] f);
        bus(1'b1, 8'h04, {24'h0, a});
        bus(1'b1, 8'h80, {24'h0, m});
        bus(1'b1, 8'h08, {26'h0, f});
    endtask
    task automatic t_ret();
        bus(1'b1, 8'h14, 32'h0);
        put(8'h00, 8'h00, 6'h15);
        for (int j = 1; j < 4; j++) bus(1'b1, 8'h10, 32'h111 * j);
        ex(5'h08, 5'd0, 8'h77);
        chk(8'h04, 32'h77);
        chk(8'h0C, 32'h333);
        ex(5'h09, 5'd0, 8'h00);
        chk(8'h14, 32'h1);
        chk_pin(gie, 1'b1);
        bus(1'b1, 8'h14, 32'h0);
        chk_pin(gie, 1'b0);
        ex(5'h07, 5'd0, 8'h00);
        chk(8'h0C, 32'h111);
        chk(8'h18, 32'h8);
        ex(5'h00, 5'd0, 8'h00);
        chk(8'h0C, 32'h112);
        chk(8'h08, 32'h15);
        $display("return test done");
    endtask
    task automatic t_dec();
        bus(1'b1, 8'h0C, 32'h0);
        put(8'h5C, 8'h01, 6'h00);
        ex(5'h03, 5'd4, 8'h00);
        ex(5'h14, 5'd0, 8'h00);
        chk(8'h18, 32'hA);
        chk(8'h0C, 32'h3);
        ex(5'h15, 5'd0, 8'h00);
        chk(8'h04, 32'hFF);
        chk(8'h80, 32'h0);
        chk(8'h08, 32'h0);
        chk(8'h18, 32'h4);
        ex(5'h02, 5'd0, 8'h00);
        ex(5'h04, 5'd0, 8'h00);
        chk(8'h08, 32'h4);
        ex(5'h05, 5'd0, 8'h30);
        ex(5'h06, 5'd4, 8'h00);
        ex(5'h01, 5'd4, 8'h00);
        chk(8'h04, 32'h7C);
        chk(8'h90, 32'h7C);
        chk(8'h08, 32'h0);
        ex(5'h16, 5'd0, 8'h00);
        chk(8'h18, 32'h14);
        bus(1'b1, 8'h18, 32'h10);
        chk(8'h18, 32'h4);
        $display("decrement and move test done");
    endtask
    task automatic t_rot();
        logic [7:0] r;
        logic [7:0] m;
        logic [2:0] k;
        logic       c;
        m = 8'h96;
        for (int j = 0; j < 16; j++)
        begin
            {c, k} = j[3:0];
            r = k[2] ? {k[1] ? c : m[0], m[7:1]} : {m[6:0], k[1] ? c : m[7]};
            put(8'h00, m, {5'h1F, c});
            ex(5'h0A + 5'(k), 5'd0, 8'h00);
            chk(8'h04, {24'h0, k[0] ? r : 8'h00});
            chk(8'h80, {24'h0, k[0] ? m : r});
            chk(8'h08, {31'h1F, k[1] ? m[k[2] ? 0 : 7] : c});
        end
        $display("rotate test done");
    endtask
    task automatic t_sub();
        logic [16:0] v [4] = '{{8'h50, 8'h30, 1'b1}, {8'h80, 8'h01, 1'b1},
                               {8'h05, 8'h05, 1'b1}, {8'h00, 8'h01, 1'b0}};
        logic [7:0]  a, m;
        logic [8:0]  s;
        logic [4:0]  h;
        logic        c;
        for (int j = 0; j < 8; j++)
        begin
            {a, m, c} = v[j[1:0]];
            s = {1'b0, a} + {1'b0, ~m} + 9'(c);
            h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'(c);
            put(a, m, {5'h18, c});
            ex(5'h12 + 5'(j[2]), 5'd0, 8'h00);
            chk(j[2] ? 8'h80 : 8'h04, {24'h0, s[7:0]});
            chk(8'h08, {28'h3, (a[7] ^ m[7]) & (s[7] ^ a[7]), ~|s[7:0], h[4], s[8]});
        end
        $display("subtract test done");
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        {cyc, we, adr, dat} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ret();
        t_dec();
        t_rot();
        t_sub();
        // unmapped word reads zero
        chk(8'h20, 32'h0);
        close_out();
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        failures++;
        close_out();
    end
endmodule // testbench
bind mcu_exec_unit exec_props u_exec_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
    .global_interrupt_enable_o(global_interrupt_enable_o));
